// >>> rif_cfg.svh
// Notes on behaviour
// - bit 7 selects set or clear of marked flags
// - timer reaching zero raises flag bit 5
// - transmit-type completions raise flag bit 4
// - receiver termination raises flag bit 3
// - command ending by itself raises flag bit 2
// - unknown command start raises flag bit 2
// - host-written idle command raises no flag
// - fifo level rising edges latch bits 1, 0
// - control bit 5 enters light sleep
// - control bit 4 enters deep sleep, oscillator off
// - control bit 3 set only by authentication
// - control bit 2 halts timer, reads zero
// - control bit 1 starts timer, reads zero
// - control bit 0 purges fifo, reads zero
// - reserved bits have no function, read zero
// - flag drives interrupt only when enabled
`ifndef RIF_CFG_SVH
`define RIF_CFG_SVH

// register indices; byte address is four times the index
`define RIF_IDX_MASK 6'h06
`define RIF_IDX_FLAGS 6'h07
`define RIF_IDX_CTRL 6'h09
`define RIF_ADDR_MASK {`RIF_IDX_MASK, 2'b00}
`define RIF_ADDR_FLAGS {`RIF_IDX_FLAGS, 2'b00}
`define RIF_ADDR_CTRL {`RIF_IDX_CTRL, 2'b00}

// reset values
`define RIF_RST_FLAGS 6'h00
`define RIF_RST_MASK 6'h00
`define RIF_RST_CTRL 1'b0

// flag and mask bit positions
`define RIF_BIT_SELECT 7
`define RIF_BIT_TIMER 5
`define RIF_BIT_TX 4
`define RIF_BIT_RX 3
`define RIF_BIT_IDLE 2
`define RIF_BIT_HIGH 1
`define RIF_BIT_LOW 0
`define RIF_FLAG_W 6

// control bit positions
`define RIF_BIT_LIGHT 5
`define RIF_BIT_DEEP 4
`define RIF_BIT_CIPHER 3
`define RIF_BIT_HALT 2
`define RIF_BIT_LAUNCH 1
`define RIF_BIT_PURGE 0

`endif

// >>> rif_pkg.sv
package rif_pkg;
	// event pulses and levels from neighbouring units, same clock
	typedef struct packed {
		logic timer_zero;
		logic tx_done;
		logic rx_done;
		logic cmd_self_end;
		logic cmd_unknown;
		logic host_idle_write;
		logic fifo_high_level;
		logic fifo_low_level;
		logic auth2_success;
	} rif_events_t;

	// control strobes and modes toward neighbouring units
	typedef struct packed {
		logic timer_halt_strobe;
		logic timer_launch_strobe;
		logic fifo_purge;
		logic light_sleep;
		logic deep_sleep;
		logic osc_enable;
		logic cipher_active;
	} rif_ctrl_t;
endpackage : rif_pkg

// >>> rif_irq_ctrl.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "rif_cfg.svh"

module rif_irq_ctrl (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// events from other units
	input rif_pkg::rif_events_t events_i,
	// control toward other units
	output rif_pkg::rif_ctrl_t ctrl_o,
	output logic irq_o
);

	logic [`RIF_FLAG_W-1:0] flags_q, flags_d;
	logic [`RIF_FLAG_W-1:0] mask_q, mask_d;
	logic light_q, light_d;
	logic deep_q, deep_d;
	logic cipher_q, cipher_d;
	logic halt_q, launch_q, purge_q;
	logic high_prev_q, low_prev_q;
	logic irq_q;
	logic [31:0] prdata_q;

	// address decode
	wire sel_mask = paddr_i == `RIF_ADDR_MASK;
	wire sel_flags = paddr_i == `RIF_ADDR_FLAGS;
	wire sel_ctrl = paddr_i == `RIF_ADDR_CTRL;
	wire mapped = sel_mask | sel_flags | sel_ctrl;
	wire setup = psel_i & ~penable_i;
	wire access = psel_i & penable_i;
	wire wr = access & pwrite_i & mapped;
	wire wr_mask = wr & sel_mask;
	wire wr_flags = wr & sel_flags;
	wire wr_ctrl = wr & sel_ctrl;

	// write fields; bit 6 and control bits 7..6 are dropped
	wire set_sel = pwdata_i[`RIF_BIT_SELECT];
	wire [`RIF_FLAG_W-1:0] marked = pwdata_i[`RIF_FLAG_W-1:0];

	// hardware set terms
	wire high_rise = events_i.fifo_high_level & ~high_prev_q;
	wire low_rise = events_i.fifo_low_level & ~low_prev_q;
	wire idle_set = (events_i.cmd_self_end
		| events_i.cmd_unknown)
		& ~events_i.host_idle_write;
	wire [`RIF_FLAG_W-1:0] hw_set = {
		events_i.timer_zero,
		events_i.tx_done,
		events_i.rx_done,
		idle_set,
		high_rise,
		low_rise
	};

	// host set or clear of marked bits
	wire [`RIF_FLAG_W-1:0] flags_host = set_sel ? (flags_q | marked) : (flags_q & ~marked);
	wire [`RIF_FLAG_W-1:0] mask_host = set_sel ? (mask_q | marked) : (mask_q & ~marked);

	assign flags_d = (wr_flags ? flags_host : flags_q) | hw_set;
	assign mask_d = wr_mask ? mask_host : mask_q;

	// sleep modes follow written value
	assign light_d = wr_ctrl ? pwdata_i[`RIF_BIT_LIGHT] : light_q;
	assign deep_d = wr_ctrl ? pwdata_i[`RIF_BIT_DEEP] : deep_q;
	// cipher: set only by authentication, host may clear
	wire cipher_clr = wr_ctrl & ~pwdata_i[`RIF_BIT_CIPHER];
	assign cipher_d = events_i.auth2_success | (cipher_q & ~cipher_clr);

	// read mux; strobe bits read as zero
	wire [7:0] ctrl_rd = {2'b00, light_q, deep_q, cipher_q, 3'b000};
	wire [7:0] rd_byte = sel_mask ? {2'b00, mask_q} :
		sel_flags ? {2'b00, flags_q} :
		sel_ctrl ? ctrl_rd : 8'h00;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			flags_q <= `RIF_RST_FLAGS;
			mask_q <= `RIF_RST_MASK;
			light_q <= `RIF_RST_CTRL;
			deep_q <= `RIF_RST_CTRL;
			cipher_q <= `RIF_RST_CTRL;
		end else begin
			flags_q <= flags_d;
			mask_q <= mask_d;
			light_q <= light_d;
			deep_q <= deep_d;
			cipher_q <= cipher_d;
		end
	end

	// one-cycle control strobes
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			halt_q <= 1'b0;
			launch_q <= 1'b0;
			purge_q <= 1'b0;
		end else begin
			halt_q <= wr_ctrl & pwdata_i[`RIF_BIT_HALT];
			launch_q <= wr_ctrl & pwdata_i[`RIF_BIT_LAUNCH];
			purge_q <= wr_ctrl & pwdata_i[`RIF_BIT_PURGE];
		end
	end

	// level history, interrupt and read data
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			high_prev_q <= 1'b0;
			low_prev_q <= 1'b0;
			irq_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			high_prev_q <= events_i.fifo_high_level;
			low_prev_q <= events_i.fifo_low_level;
			irq_q <= |(flags_d & mask_d);
			if (setup) begin
				prdata_q <= {24'h00_0000, rd_byte};
			end
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = 1'b1;
	assign pslverr_o = access & ~mapped;
	assign irq_o = irq_q;

	assign ctrl_o.timer_halt_strobe = halt_q;
	assign ctrl_o.timer_launch_strobe = launch_q;
	assign ctrl_o.fifo_purge = purge_q;
	assign ctrl_o.light_sleep = light_q;
	assign ctrl_o.deep_sleep = deep_q;
	assign ctrl_o.osc_enable = ~deep_q;
	assign ctrl_o.cipher_active = cipher_q;

endmodule : rif_irq_ctrl

// >>> rif_irq_ctrl_asserts.sv
`timescale 1ns/1ps
`include "rif_cfg.svh"
module rif_irq_ctrl_asserts (
	input wire logic sys_clk_i, reset_i, psel_i, penable_i, pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i, prdata_o,
	input wire logic pready_o, pslverr_o, irq_o,
	input rif_pkg::rif_events_t events_i,
	input rif_pkg::rif_ctrl_t ctrl_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	wire acc = psel_i & penable_i;
	wire wc = acc & pwrite_i & (paddr_i == `RIF_ADDR_CTRL);
	wire rd = acc & !pwrite_i;
	AST_HALT: assert property (wc |=> ctrl_o.timer_halt_strobe == $past(pwdata_i[2]))
		else $error("halt");
	AST_LAUNCH: assert property (wc |=> ctrl_o.timer_launch_strobe == $past(pwdata_i[1]))
		else $error("launch");
	AST_PURGE: assert property (ctrl_o.fifo_purge |-> $past(wc & pwdata_i[0]) ##1 !ctrl_o.fifo_purge)
		else $error("purge");
	AST_SLEEP: assert property (wc |=> ctrl_o.light_sleep == $past(pwdata_i[5]))
		else $error("sleep");
	AST_OSC: assert property (ctrl_o.osc_enable != ctrl_o.deep_sleep) else $error("osc");
	AST_CIPHER: assert property ($rose(ctrl_o.cipher_active) |-> $past(events_i.auth2_success))
		else $error("cipher");
	AST_CTRLRD: assert property (rd && paddr_i == `RIF_ADDR_CTRL |-> prdata_o[2:0] == 3'h0)
		else $error("ctrl read");
	AST_FLAGRD: assert property (rd && paddr_i == `RIF_ADDR_FLAGS |-> prdata_o[31:6] == 26'h0)
		else $error("flag read");
	AST_IRQ: assert property ($rose(irq_o) |-> $past(events_i != 9'h0 || acc & pwrite_i))
		else $error("irq");
	AST_SLVERR: assert property (acc |-> pslverr_o == !(paddr_i == `RIF_ADDR_MASK
		|| paddr_i == `RIF_ADDR_FLAGS || paddr_i == `RIF_ADDR_CTRL))
		else $error("slave error");
endmodule : rif_irq_ctrl_asserts
bind rif_irq_ctrl rif_irq_ctrl_asserts rif_irq_ctrl_asserts_i (.*);

// >>> rif_host.sv
`timescale 1ns/1ps
module rif_host (
	input wire logic clk_i,
	input wire logic pready_i,
	input wire logic [31:0] prdata_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	int to_cnt = 0;
	initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
	// setup, then access until ready or 16 cycles pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (!pready_i && n < 16);
		if (n >= 16) to_cnt++;
		q = prdata_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask : xfer
endmodule : rif_host

// >>> rif_irq_ctrl_bench.sv
`timescale 1ns/1ps
`include "rif_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %0t got %h want %h", $time, g, e); end end
module rif_irq_ctrl_bench;
	logic sys_clk_i = 0, reset_i = 1, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, q;
	rif_pkg::rif_events_t events_i = '0;
	rif_pkg::rif_ctrl_t ctrl_o;
	int num_errors = 0, total_checks = 0;
	logic [16:0] rows [9] = '{17'h10020, 17'h08010, 17'h04008, 17'h02004, 17'h01004,
		17'h02800, 17'h01800, 17'h00402, 17'h00201};
	rif_irq_ctrl rif_irq_ctrl_i (.*);
	rif_host rif_host_i (.clk_i(sys_clk_i), .pready_i(pready_o), .prdata_i(prdata_o),
		.psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
		.pwdata_o(pwdata_i));
	initial forever #20 sys_clk_i = ~sys_clk_i;
	task end_sim;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rif_host_i.xfer(1'b1, a, {24'h0, d}, q);
		@(negedge sys_clk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rif_host_i.xfer(1'b0, a, 32'h0, q);
		`CHK(q, {24'h0, e})
	endtask : rd
	task automatic ev(input logic [8:0] v);
		@(posedge sys_clk_i);
		events_i <= v;
		@(posedge sys_clk_i);
		events_i <= '0;
		@(negedge sys_clk_i);
	endtask : ev
	initial begin
		repeat (4) @(posedge sys_clk_i);
		`CHK({irq_o, ctrl_o}, 8'h02)
		reset_i <= 1'b0;
		wr(`RIF_ADDR_MASK, 8'hBF);
		foreach (rows[i]) begin
			wr(`RIF_ADDR_FLAGS, 8'h3F);
			ev(rows[i][16:8]);
			`CHK(irq_o, |rows[i][7:0])
			rd(`RIF_ADDR_FLAGS, rows[i][7:0]);
		end
		$display("event rows done");
		wr(`RIF_ADDR_FLAGS, 8'hFF);
		rd(`RIF_ADDR_FLAGS, 8'h3F);
		wr(`RIF_ADDR_FLAGS, 8'h15);
		rd(`RIF_ADDR_FLAGS, 8'h2A);
		@(posedge sys_clk_i);
		events_i <= 9'h040;
		rif_host_i.xfer(1'b1, `RIF_ADDR_FLAGS, 32'h08, q);
		events_i <= '0;
		rd(`RIF_ADDR_FLAGS, 8'h2A);
		wr(`RIF_ADDR_MASK, 8'h3F);
		`CHK(irq_o, 1'b0)
		wr(`RIF_ADDR_CTRL, 8'hFF);
		`CHK(ctrl_o, 7'h7C)
		rd(`RIF_ADDR_CTRL, 8'h30);
		ev(9'h001);
		rd(`RIF_ADDR_CTRL, 8'h38);
		rd(8'h20, 8'h00);
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		@(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(negedge sys_clk_i);
		`CHK({irq_o, ctrl_o}, 8'h02)
		rd(`RIF_ADDR_CTRL, 8'h00);
		rd(`RIF_ADDR_FLAGS, 8'h00);
		$display("register tests done");
		`CHK(rif_host_i.to_cnt, 0)
		end_sim;
	end
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		num_errors++;
		end_sim;
	end
endmodule : rif_irq_ctrl_bench
